// ==== psl_pll_map.svh ====
`ifndef PSL_PLL_MAP_SVH
`define PSL_PLL_MAP_SVH

// serial word and control bits
`define PSL_WORD_W 24
`define PSL_CTRL_MSB 1
`define PSL_CTRL_LSB 0
`define PSL_SEL_REF 2'h0
`define PSL_SEL_FB 2'h1
`define PSL_SEL_FUNC 2'h2
`define PSL_SEL_INIT 2'h3

// reference divider latch fields
`define PSL_REF_RATIO_MSB 15
`define PSL_REF_RATIO_LSB 2
`define PSL_REF_ABP_MSB 17
`define PSL_REF_ABP_LSB 16
`define PSL_REF_TEST_MSB 19
`define PSL_REF_TEST_LSB 18
`define PSL_REF_LOCK_PRECISION 20

// feedback divider latch fields
`define PSL_FB_RATIO_MSB 20
`define PSL_FB_RATIO_LSB 8
`define PSL_FB_GAIN 21

// function / initialization latch fields
`define PSL_FN_CRST 2
`define PSL_FN_POWER_DOWN_FIRST 3
`define PSL_FN_MUX_MSB 6
`define PSL_FN_MUX_LSB 4
`define PSL_FN_POL 7
`define PSL_FN_TRI 8
`define PSL_FN_FLEN 9
`define PSL_FN_FLMODE 10
`define PSL_FN_TC_MSB 14
`define PSL_FN_TC_LSB 11
`define PSL_FN_CS1_MSB 17
`define PSL_FN_CS1_LSB 15
`define PSL_FN_CS2_MSB 20
`define PSL_FN_CS2_LSB 18
`define PSL_FN_POWER_DOWN_SECOND 21

// reset values of the latches
`define PSL_REF_RESET 24'h000004
`define PSL_FB_RESET 24'h000101
`define PSL_FN_RESET 24'h000002

// output multiplexer codes
`define PSL_MUX_LOW 3'h0
`define PSL_MUX_DLOCK 3'h1
`define PSL_MUX_FBDIV 3'h2
`define PSL_MUX_HIGH 3'h3
`define PSL_MUX_REFDIV 3'h4
`define PSL_MUX_ALOCK 3'h5
`define PSL_MUX_SDATA 3'h6
`define PSL_MUX_GND 3'h7

// timing
`define PSL_CLK_NS 25
`define PSL_LOCK_SET_NS 15
`define PSL_LOCK_CLR_NS 25
`define PSL_LOCK_SET_CYC ((`PSL_LOCK_SET_NS + `PSL_CLK_NS - 1) / `PSL_CLK_NS)
`define PSL_LOCK_CLR_CYC (`PSL_LOCK_CLR_NS / `PSL_CLK_NS)
`define PSL_LOCK_RUN_SHORT 3
`define PSL_LOCK_RUN_LONG 5
`define PSL_ERR_W 8
`define PSL_ERR_MAX 8'hFF

`endif

// ==== psl_pkg.sv ====
package psl_pkg;

  typedef enum logic [1:0] {
    PFD_IDLE,
    PFD_UP,
    PFD_DOWN,
    PFD_CLEAR
  } psl_pfd_state_type;

  typedef logic [23:0] psl_word_type;

endpackage : psl_pkg

// ==== psl_divider.sv ====
`include "psl_pll_map.svh"

module psl_divider #(
  parameter int WIDTH = 14
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic edge_tick,
  input wire logic hold,
  input wire logic [WIDTH-1:0] ratio,
  output logic out_pulse
);

  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("psl_divider: WIDTH out of range");
  end

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_inc;

  assign count_inc = count_r + {{(WIDTH-1){1'b0}}, 1'b1};

  // ratio 0 behaves as 1; hold parks the counter at its load point
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
      out_pulse <= 1'b0;
    end else if (hold) begin
      count_r <= '0;
      out_pulse <= 1'b0;
    end else if (edge_tick) begin
      if (count_inc >= ratio) begin
        count_r <= '0;
        out_pulse <= 1'b1;
      end else begin
        count_r <= count_inc;
        out_pulse <= 1'b0;
      end
    end else begin
      out_pulse <= 1'b0;
    end
  end

endmodule : psl_divider

// ==== psl_lock_detect.sv ====
`include "psl_pll_map.svh"

module psl_lock_detect (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic measure,
  input wire logic [`PSL_ERR_W-1:0] error_cycles,
  input wire logic need_long_run,
  output logic locked
);

  logic [2:0] good_run_r;
  logic [2:0] run_target;
  logic [2:0] run_next;

  assign run_target = need_long_run ? 3'(`PSL_LOCK_RUN_LONG) : 3'(`PSL_LOCK_RUN_SHORT);
  assign run_next = (good_run_r == 3'h7) ? good_run_r : good_run_r + 3'h1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      good_run_r <= 3'h0;
      locked <= 1'b0;
    end else if (clear) begin
      good_run_r <= 3'h0;
      locked <= 1'b0;
    end else if (measure) begin
      if (error_cycles < `PSL_ERR_W'(`PSL_LOCK_SET_CYC)) begin
        good_run_r <= run_next;
        if (run_next >= run_target) begin
          locked <= 1'b1;
        end
      end else begin
        good_run_r <= 3'h0;
      end
      if (error_cycles > `PSL_ERR_W'(`PSL_LOCK_CLR_CYC)) begin
        locked <= 1'b0;
      end
    end
  end

endmodule : psl_lock_detect

// ==== psl_pll_core.sv ====
`include "psl_pll_map.svh"

module psl_pll_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic chip_enable,
  input wire logic reference_input,
  input wire logic rf_input,
  output logic multiplexed_output_pin,
  output logic analog_lock_out,
  output logic analog_lock_oe_n,
  output logic pump_up,
  output logic pump_down,
  output logic pump_tristate,
  output logic [2:0] pump_current_setting,
  output logic device_disabled
);

  psl_pkg::psl_word_type shift_r;
  psl_pkg::psl_word_type ref_latch_r;
  psl_pkg::psl_word_type fb_latch_r;
  psl_pkg::psl_word_type func_latch_r;
  logic sclk_prev_r;
  logic load_prev_r;
  logic ref_prev_r;
  logic rf_prev_r;
  logic sclk_rise;
  logic load_rise;
  logic ref_rise;
  logic rf_rise;
  logic [1:0] latch_select;
  logic init_pending_r;
  logic reset_pulse_r;
  logic sleep_r;
  logic disabled;
  logic divider_hold;
  logic ref_pulse;
  logic fb_pulse;
  logic [13:0] ref_ratio;
  logic [12:0] fb_ratio;
  psl_pkg::psl_pfd_state_type pfd_state_r;
  psl_pkg::psl_pfd_state_type pfd_state_nxt;
  logic [`PSL_ERR_W-1:0] err_cnt_r;
  logic [2:0] clear_cnt_r;
  logic measure;
  logic [`PSL_ERR_W-1:0] measured_err;
  logic dig_lock;
  logic ref_div_level_r;
  logic fb_div_level_r;
  logic up_nxt;
  logic down_nxt;
  logic pol_swap;
  logic [2:0] mux_sel;

  function automatic logic [2:0] backlash_cycles(input logic [1:0] field);
    backlash_cycles = {1'b0, field} + 3'h1;
  endfunction : backlash_cycles

  function automatic logic [`PSL_ERR_W-1:0] err_step(input logic [`PSL_ERR_W-1:0] value);
    err_step = (value == `PSL_ERR_MAX) ? value : value + `PSL_ERR_W'(1);
  endfunction : err_step

  // all pins are taken as synchronous to clk, so plain edge detection
  assign sclk_rise = serial_clock & ~sclk_prev_r;
  assign load_rise = load_strobe & ~load_prev_r;
  assign ref_rise = reference_input & ~ref_prev_r;
  assign rf_rise = rf_input & ~rf_prev_r;
  assign latch_select = shift_r[`PSL_CTRL_MSB:`PSL_CTRL_LSB];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_r <= 1'b0;
      load_prev_r <= 1'b0;
      ref_prev_r <= 1'b0;
      rf_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= serial_clock;
      load_prev_r <= load_strobe;
      ref_prev_r <= reference_input;
      rf_prev_r <= rf_input;
    end
  end

  // shifting is never gated by power-down
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= '0;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[`PSL_WORD_W-2:0], serial_data};
    end
  end

  // one clock domain: a latch word changes in a single edge, so the
  // dividers never see half of a new ratio
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_latch_r <= `PSL_REF_RESET;
      fb_latch_r <= `PSL_FB_RESET;
      func_latch_r <= `PSL_FN_RESET;
    end else if (load_rise) begin
      case (latch_select)
        `PSL_SEL_REF: ref_latch_r <= shift_r;
        `PSL_SEL_FB: fb_latch_r <= shift_r;
        `PSL_SEL_FUNC: func_latch_r <= shift_r;
        `PSL_SEL_INIT: func_latch_r <= shift_r;
        default: func_latch_r <= func_latch_r;
      endcase
    end
  end

  // init load pulses the dividers; the first feedback load after it repeats once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_pending_r <= 1'b0;
      reset_pulse_r <= 1'b0;
    end else begin
      reset_pulse_r <= 1'b0;
      if (load_rise && latch_select == `PSL_SEL_INIT) begin
        init_pending_r <= 1'b1;
        reset_pulse_r <= 1'b1;
      end else if (load_rise && latch_select == `PSL_SEL_FB && init_pending_r) begin
        init_pending_r <= 1'b0;
        reset_pulse_r <= 1'b1;
      end
    end
  end

  // power-down 1 alone sleeps at once; with power-down 2 it waits for a reference divider pulse or a divider reset pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_r <= 1'b0;
    end else if (!func_latch_r[`PSL_FN_POWER_DOWN_FIRST]) begin
      sleep_r <= 1'b0;
    end else if (!func_latch_r[`PSL_FN_POWER_DOWN_SECOND]) begin
      sleep_r <= 1'b1;
    end else if (ref_pulse || reset_pulse_r) begin
      sleep_r <= 1'b1;
    end
  end

  assign disabled = ~chip_enable | sleep_r;
  assign divider_hold = disabled | func_latch_r[`PSL_FN_CRST] | reset_pulse_r;
  assign ref_ratio = ref_latch_r[`PSL_REF_RATIO_MSB:`PSL_REF_RATIO_LSB];
  assign fb_ratio = fb_latch_r[`PSL_FB_RATIO_MSB:`PSL_FB_RATIO_LSB];

  psl_divider #(
    .WIDTH(14)
  ) u_ref_div (
    .clk(clk),
    .reset_n(reset_n),
    .edge_tick(ref_rise),
    .hold(divider_hold),
    .ratio(ref_ratio),
    .out_pulse(ref_pulse)
  );

  psl_divider #(
    .WIDTH(13)
  ) u_fb_div (
    .clk(clk),
    .reset_n(reset_n),
    .edge_tick(rf_rise),
    .hold(divider_hold),
    .ratio(fb_ratio),
    .out_pulse(fb_pulse)
  );

  // detector: first edge opens a pump, second closes into a common clear phase
  always_comb begin
    pfd_state_nxt = pfd_state_r;
    measure = 1'b0;
    measured_err = err_cnt_r;
    case (pfd_state_r)
      psl_pkg::PFD_IDLE: begin
        if (ref_pulse && fb_pulse) begin
          pfd_state_nxt = psl_pkg::PFD_CLEAR;
          measure = 1'b1;
          measured_err = '0;
        end else if (ref_pulse) begin
          pfd_state_nxt = psl_pkg::PFD_UP;
        end else if (fb_pulse) begin
          pfd_state_nxt = psl_pkg::PFD_DOWN;
        end
      end
      psl_pkg::PFD_UP: begin
        if (fb_pulse) begin
          pfd_state_nxt = psl_pkg::PFD_CLEAR;
          measure = 1'b1;
          measured_err = err_step(err_cnt_r);
        end
      end
      psl_pkg::PFD_DOWN: begin
        if (ref_pulse) begin
          pfd_state_nxt = psl_pkg::PFD_CLEAR;
          measure = 1'b1;
          measured_err = err_step(err_cnt_r);
        end
      end
      psl_pkg::PFD_CLEAR: begin
        if (clear_cnt_r <= 3'h1) begin
          pfd_state_nxt = psl_pkg::PFD_IDLE;
        end
      end
      default: pfd_state_nxt = psl_pkg::PFD_IDLE;
    endcase
    if (disabled) begin
      pfd_state_nxt = psl_pkg::PFD_IDLE;
      measure = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pfd_state_r <= psl_pkg::PFD_IDLE;
      err_cnt_r <= '0;
      clear_cnt_r <= 3'h0;
    end else begin
      pfd_state_r <= pfd_state_nxt;
      if (pfd_state_nxt == psl_pkg::PFD_UP || pfd_state_nxt == psl_pkg::PFD_DOWN) begin
        err_cnt_r <= (pfd_state_r == psl_pkg::PFD_IDLE) ? '0 : err_step(err_cnt_r);
      end
      if (pfd_state_r != psl_pkg::PFD_CLEAR) begin
        // overlap of both pumps is the minimum width; narrow settings invite dead zone
        clear_cnt_r <= backlash_cycles(ref_latch_r[`PSL_REF_ABP_MSB:`PSL_REF_ABP_LSB]);
      end else if (clear_cnt_r != 3'h0) begin
        clear_cnt_r <= clear_cnt_r - 3'h1;
      end
    end
  end

  psl_lock_detect u_lock (
    .clk(clk),
    .reset_n(reset_n),
    .clear(disabled),
    .measure(measure),
    .error_cycles(measured_err),
    .need_long_run(ref_latch_r[`PSL_REF_LOCK_PRECISION]),
    .locked(dig_lock)
  );

  // divided outputs toggle on each divider pulse to give a visible square wave
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_div_level_r <= 1'b0;
      fb_div_level_r <= 1'b0;
    end else begin
      if (ref_pulse) begin
        ref_div_level_r <= ~ref_div_level_r;
      end
      if (fb_pulse) begin
        fb_div_level_r <= ~fb_div_level_r;
      end
    end
  end

  assign pol_swap = ~func_latch_r[`PSL_FN_POL];
  assign up_nxt = (pfd_state_nxt == psl_pkg::PFD_UP) || (pfd_state_nxt == psl_pkg::PFD_CLEAR);
  assign down_nxt = (pfd_state_nxt == psl_pkg::PFD_DOWN) || (pfd_state_nxt == psl_pkg::PFD_CLEAR);
  assign mux_sel = func_latch_r[`PSL_FN_MUX_MSB:`PSL_FN_MUX_LSB];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pump_up <= 1'b0;
      pump_down <= 1'b0;
      pump_tristate <= 1'b1;
      pump_current_setting <= 3'h0;
      device_disabled <= 1'b1;
    end else begin
      pump_up <= pol_swap ? down_nxt : up_nxt;
      pump_down <= pol_swap ? up_nxt : down_nxt;
      pump_tristate <= disabled | func_latch_r[`PSL_FN_TRI];
      pump_current_setting <= fb_latch_r[`PSL_FB_GAIN] ?
        func_latch_r[`PSL_FN_CS2_MSB:`PSL_FN_CS2_LSB] :
        func_latch_r[`PSL_FN_CS1_MSB:`PSL_FN_CS1_LSB];
      device_disabled <= disabled;
    end
  end

  // open drain: pulled low only while either pump is active
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      analog_lock_out <= 1'b0;
      analog_lock_oe_n <= 1'b1;
    end else begin
      analog_lock_out <= 1'b0;
      analog_lock_oe_n <= ~(up_nxt | down_nxt);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      multiplexed_output_pin <= 1'b0;
    end else begin
      case (mux_sel)
        `PSL_MUX_LOW: multiplexed_output_pin <= 1'b0;
        `PSL_MUX_DLOCK: multiplexed_output_pin <= dig_lock;
        `PSL_MUX_FBDIV: multiplexed_output_pin <= fb_div_level_r;
        `PSL_MUX_HIGH: multiplexed_output_pin <= 1'b1;
        `PSL_MUX_REFDIV: multiplexed_output_pin <= ref_div_level_r;
        `PSL_MUX_ALOCK: multiplexed_output_pin <= ~(up_nxt | down_nxt);
        `PSL_MUX_SDATA: multiplexed_output_pin <= shift_r[`PSL_WORD_W-1];
        `PSL_MUX_GND: multiplexed_output_pin <= 1'b0;
        default: multiplexed_output_pin <= 1'b0;
      endcase
    end
  end

endmodule : psl_pll_core

// ==== psl_host_model.sv ====
module psl_host_model (
  input wire logic clk,
  output logic serial_clock,
  output logic serial_data,
  output logic load_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // clk cycles per serial half period; the bench sets it to 1 or 2
  int half = 2;

  initial begin
    serial_clock = 1'h0;
    serial_data = 1'h0;
    load_strobe = 1'h0;
  end

  task automatic shift(input psl_pkg::psl_word_type w, input int n, input logic ld);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data <= w[i];
      repeat (half) @(posedge clk);
      serial_clock <= 1'h1;
      repeat (half) @(posedge clk);
      serial_clock <= 1'h0;
    end
    // undriven data must not keep looking like the last bit
    serial_data <= ~serial_data;
    repeat (half) @(posedge clk);
    if (ld) begin
      load_strobe <= 1'h1;
      repeat (2) @(posedge clk);
      load_strobe <= 1'h0;
      repeat (2) @(posedge clk);
    end
  endtask : shift
endmodule : psl_host_model

// ==== psl_pll_core_props.sv ====
module psl_pll_core_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reference_input,
  input wire logic rf_input,
  input wire logic load_strobe,
  input wire logic chip_enable,
  input wire logic analog_lock_out,
  input wire logic analog_lock_oe_n,
  input wire logic pump_up,
  input wire logic pump_down,
  input wire logic pump_tristate,
  input wire logic [2:0] pump_current_setting,
  input wire logic device_disabled
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] since_edge;
  logic [3:0] since_load;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // saturating ages; a few cycles of history is all the rules need
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) since_edge <= 4'hF;
    else if ($rose(reference_input) || $rose(rf_input)) since_edge <= 4'h0;
    else if (since_edge != 4'hF) since_edge <= since_edge + 4'h1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) since_load <= 4'hF;
    else if ($rose(load_strobe)) since_load <= 4'h0;
    else if (since_load != 4'hF) since_load <= since_load + 4'h1;
  end

  a_disable_on_ce: assert property (!chip_enable |=> device_disabled)
    else $error("not disabled after chip enable low");
  a_enable_needs_ce: assert property ($fell(device_disabled) |-> $past(chip_enable))
    else $error("enabled without chip enable");
  a_tristate_when_off: assert property (!chip_enable [*2] |=> pump_tristate)
    else $error("pump driven while disabled");
  a_pumps_idle_off: assert property (!chip_enable [*2] |=> !pump_up && !pump_down)
    else $error("pump active while disabled");
  a_lock_data_low: assert property (analog_lock_out == 1'h0)
    else $error("open drain data not low");
  a_lock_pin_idle: assert property ((!pump_up && !pump_down) [*2] |-> analog_lock_oe_n)
    else $error("lock pin pulled with pumps idle");
  a_lock_pin_pulse: assert property ((pump_up || pump_down) [*2] |-> !analog_lock_oe_n)
    else $error("lock pin released with pump active");
  a_pump_has_cause: assert property ($rose(pump_up || pump_down) |-> since_edge <= 4'h4)
    else $error("pump started without input edge");
  a_current_on_load: assert property ($changed(pump_current_setting) |-> since_load <= 4'h4)
    else $error("current setting changed without load");
endmodule : psl_pll_core_props

bind psl_pll_core psl_pll_core_props psl_pll_core_props_inst (
  .clk(clk), .reset_n(reset_n), .reference_input(reference_input), .rf_input(rf_input),
  .load_strobe(load_strobe), .chip_enable(chip_enable), .analog_lock_out(analog_lock_out),
  .analog_lock_oe_n(analog_lock_oe_n), .pump_up(pump_up), .pump_down(pump_down),
  .pump_tristate(pump_tristate), .pump_current_setting(pump_current_setting),
  .device_disabled(device_disabled)
);

// ==== psl_pll_core_tb.sv ====
module psl_pll_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, chip_enable, reference_input, rf_input, pin_q;
  logic serial_clock, serial_data, load_strobe, multiplexed_output_pin;
  logic analog_lock_out, analog_lock_oe_n, pump_up, pump_down, pump_tristate, device_disabled;
  logic [2:0] pump_current_setting, cs1, cs2;
  logic [2:0] codes[4] = '{3'h0, 3'h3, 3'h5, 3'h7};
  int n_errors, compares, toggles, both, low_oe, ups, rr, e, r;

  psl_pll_core psl_pll_core_inst (
    .clk(clk), .reset_n(reset_n), .serial_clock(serial_clock), .serial_data(serial_data),
    .load_strobe(load_strobe), .chip_enable(chip_enable), .reference_input(reference_input),
    .rf_input(rf_input), .multiplexed_output_pin(multiplexed_output_pin),
    .analog_lock_out(analog_lock_out), .analog_lock_oe_n(analog_lock_oe_n), .pump_up(pump_up),
    .pump_down(pump_down), .pump_tristate(pump_tristate),
    .pump_current_setting(pump_current_setting), .device_disabled(device_disabled)
  );

  psl_host_model psl_host_model_inst (
    .clk(clk), .serial_clock(serial_clock), .serial_data(serial_data), .load_strobe(load_strobe)
  );

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // pre-edge values only, so no race with the design's own updates
  always @(posedge clk) begin
    pin_q <= multiplexed_output_pin;
    toggles += int'(pin_q !== multiplexed_output_pin);
    both += int'((pump_up && pump_down) === 1'h1);
    ups += int'(pump_up === 1'h1);
    low_oe += int'(analog_lock_oe_n === 1'h0);
  end

  function automatic psl_pkg::psl_word_type fnw(input logic [2:0] mux, input logic [2:0] c1,
      input logic [2:0] c2, input logic crst, input logic [1:0] ctl);
    return {3'h0, c2, c1, 4'h0, 4'h1, mux, 1'h0, crst, ctl};
  endfunction : fnw

  function automatic psl_pkg::psl_word_type refw(input logic lock_precision, input logic [1:0] abp,
      input logic [13:0] ratio);
    return {3'h0, lock_precision, 2'h0, abp, ratio, 2'h0};
  endfunction : refw

  function automatic psl_pkg::psl_word_type fbw(input logic gain, input logic [12:0] ratio);
    return {2'h0, gain, ratio, 6'h00, 2'h1};
  endfunction : fbw

  task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic check_count(input string what, input int exp, input int got);
    compares++;
    if (got != exp) begin
      n_errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_count

  task automatic wr(input psl_pkg::psl_word_type w);
    @(posedge clk);
    psl_host_model_inst.shift(w, 24, 1'h1);
    repeat (2) @(negedge clk);
  endtask : wr

  // one detector period is 14 cycles, long enough for the widest clear
  task automatic pulse(input int n, input logic [1:0] m, input int lag);
    @(negedge clk);
    toggles = 0;
    both = 0;
    low_oe = 0;
    ups = 0;
    for (int i = 0; i < n * 14; i++) begin
      @(posedge clk);
      reference_input <= m[0] && i % 14 < 2;
      rf_input <= m[1] && i % 14 >= lag && i % 14 < lag + 2;
    end
    repeat (2) @(negedge clk);
  endtask : pulse

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // whole run is near 5k cycles; 40k means a hang
  initial begin
    #1ms;
    n_errors++;
    wrap_up();
  end

  initial begin
    reset_n = 1'h0;
    chip_enable = 1'h1;
    reference_input = 1'h0;
    rf_input = 1'h0;
    r = $urandom(24050);
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    repeat (3) @(negedge clk);
    check("mux", 3'h0, multiplexed_output_pin);
    check("current", 3'h0, pump_current_setting);
    check("disabled", 3'h0, device_disabled);
    for (int k = 0; k < 4; k++) begin
      psl_host_model_inst.half = 1 + k % 2;
      cs1 = 3'($urandom);
      cs2 = 3'($urandom);
      wr(fnw(3'h0, cs1, cs2, 1'h0, 2'(2 + k % 2)));
      wr(fbw(1'h0, 13'h1));
      check("current", cs1, pump_current_setting);
      wr(fbw(1'h1, 13'h1));
      wr(refw(1'h0, 2'h3, 14'h5));
      check("current", cs2, pump_current_setting);
    end
    // detector idle here, so the analog lock level reads high
    foreach (codes[i]) begin
      wr(fnw(codes[i], 3'h0, 3'h0, 1'h0, 2'h2));
      check("mux", {2'h0, codes[i] == 3'h3 || codes[i] == 3'h5}, multiplexed_output_pin);
    end
    wr(fnw(3'h6, 3'h0, 3'h0, 1'h0, 2'h2) | 24'h800000);
    check("shift msb", 3'h1, multiplexed_output_pin);
    @(posedge clk);
    psl_host_model_inst.shift(24'h000000, 1, 1'h0);
    repeat (4) @(negedge clk);
    check("shift msb", 3'h0, multiplexed_output_pin);
    wr(fnw(3'h4, 3'h0, 3'h0, 1'h1, 2'h2));
    pulse(6, 2'h1, 0);
    check_count("held divider", 0, toggles);
    for (int k = 0; k < 3; k++) begin
      rr = 1 + $urandom % 7;
      e = rr + $urandom % 12;
      wr(refw(1'h0, 2'h1, 14'(rr)));
      wr(fnw(3'h4, 3'h0, 3'h0, 1'h0, 2'h3));
      wr(fbw(1'h0, 13'(rr + 1)));
      pulse(e, 2'h1, 0);
      check_count("ref divider", e / rr, toggles);
      wr(fnw(3'h2, 3'h0, 3'h0, 1'h0, 2'h2));
      pulse(e, 2'h2, 0);
      check_count("fb divider", e / (rr + 1), toggles);
    end
    @(posedge clk);
    chip_enable <= 1'h0;
    wr(fnw(3'h1, 3'h5, 3'h5, 1'h0, 2'h2));
    wr(fbw(1'h0, 13'h1));
    check("disabled", 3'h1, device_disabled);
    check("tristate", 3'h1, pump_tristate);
    check("current", 3'h5, pump_current_setting);
    @(posedge clk);
    chip_enable <= 1'h1;
    repeat (3) @(negedge clk);
    check("disabled", 3'h0, device_disabled);
    for (int p = 0; p < 2; p++) begin
      wr(refw(1'(p), 2'(p + 1), 14'h1));
      pulse(2 + 2 * p, 2'h3, 0);
      check_count("clear width", (2 + 2 * p) * (p + 2), both);
      check_count("lock pulses", (2 + 2 * p) * (p + 2), low_oe);
      check("lock early", 3'h0, multiplexed_output_pin);
      pulse(1, 2'h3, 0);
      check("lock set", 3'h1, multiplexed_output_pin);
      pulse(1, 2'h3, 3);
      check("lock lost", 3'h0, multiplexed_output_pin);
      // reference leads by three cycles, then the common clear phase
      check_count("pump up", 3 + p + 2, ups);
    end
    wrap_up();
  end
endmodule : psl_pll_core_tb
